// ===== design/rmf_pkg.sv
/*
  Package for the regulator mode, fault and reset controller: modes,
  timing constants and the packed carriers of comparator inputs.
  Assumes a 100 MHz system clock.
*/
package rmf_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned TICK_US       = 1;
  localparam int unsigned TICK_CYC      = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned FAULT_MS      = 10;
  localparam int unsigned FAULT_TICKS   = FAULT_MS * 1000 / TICK_US;
  localparam int unsigned RETRY_MS      = 100;
  localparam int unsigned RETRY_TICKS   = RETRY_MS * 1000 / TICK_US;
  localparam int unsigned RST_FIX_MS    = 10;
  localparam int unsigned RST_FIX_TICKS = RST_FIX_MS * 1000 / TICK_US;
  localparam int unsigned FILT_US       = 20;
  localparam int unsigned FILT_TICKS    = FILT_US / TICK_US;
  localparam int unsigned OSC_HZ        = 300_000;
  localparam int unsigned OSC_HALF_CYC  = CLK_HZ / OSC_HZ / 2;
  localparam int unsigned CNT_W         = 18;
  localparam int unsigned OSC_W         = 9;

  typedef enum logic [1:0] {
    RMF_MODE_OFF = 2'b00,
    RMF_MODE_STD = 2'b01,
    RMF_MODE_INV = 2'b10,
    RMF_MODE_NOSEQ = 2'b11
  } rmf_mode_t;

  // Per-regulator fault state, one-hot
  typedef enum logic [3:0] {
    RMF_F_OFF   = 4'b0001,
    RMF_F_RUN   = 4'b0010,
    RMF_F_LIMIT = 4'b0100,
    RMF_F_RETRY = 4'b1000
  } rmf_fault_st_t;

  typedef struct packed {
    logic sw_i_peak;
    logic sw_i_valley;
    logic ldo_cs_trip;
    logic ldo_drv_sat;
    logic cs_tied_boost;
    logic sw_out_ok;
    logic ldo_out_ok;
  } rmf_sense_t;

  typedef struct packed {
    logic bst_i_upper;
    logic bst_i_valley;
    logic bst_above_6v;
    logic bst_at_limit;
  } rmf_boost_t;
endpackage : rmf_pkg

// ===== design/rmf_ctrl.sv
/*
  Regulator mode, fault and reset controller: mode decode, over-current
  timing with retry for switcher and linear regulator, reset supervisor,
  oscillator output or sync input, hysteretic boost switch control.
  Assumes comparator flags arrive asynchronously from analog blocks and
  that the reset pin has an external pull-up.
*/
// How it works
// - Enable pair decodes four operating modes
// - Floating enables read low, regulators disabled
// - Reset held 10ms plus programmed interval
// - Reset asserted when either output out of regulation
// - 20us filter qualifies out-of-regulation before reset
// - Reset held low until delay timer expires
// - Reset open-drain, pulls low only
// - Switcher peak limit, off until valley
// - Switcher overcurrent 10ms shuts off, starts retry
// - After 100ms retry, rerun and recheck 10ms
// - Current-limited switcher runs unsynchronised
// - Linear trip limits 10ms, then off, retry
// - Linear retry after 100ms, recheck 10ms
// - Tied sense pin uses driver saturation
// - Clock pin output when open, input grounded
// - Output clock 50% duty, inverted phase
// - Oscillator default 300kHz
// - Boost hysteretic 1.0A/600mA, scaled above 6V
// - Boost switch off while at regulation limit
// - Both regulators coordinated, never independent
`timescale 1ns/1ns
`default_nettype none
module rmf_ctrl
  import rmf_pkg::*;
#(
  parameter int unsigned FAULT_TICKS_P = rmf_pkg::FAULT_TICKS,
  parameter int unsigned RETRY_TICKS_P = rmf_pkg::RETRY_TICKS,
  parameter int unsigned RST_FIX_P     = rmf_pkg::RST_FIX_TICKS,
  parameter int unsigned FILT_TICKS_P  = rmf_pkg::FILT_TICKS
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              enable_select_a_i,
  input  wire logic              enable_select_b_i,
  input  wire logic              clock_pin_config_i,
  input  wire logic              sync_clock_pin_i,
  input  wire logic              reset_delay_timer_pin_i,
  input  wire rmf_pkg::rmf_sense_t sense_i,
  input  wire rmf_pkg::rmf_boost_t boost_i,
  output logic [1:0]             mode_o,
  output logic                   sw_enable_o,
  output logic                   sw_high_side_o,
  output logic                   sw_sync_o,
  output logic                   ldo_enable_o,
  output logic                   ldo_limit_o,
  output logic                   boost_switch_o,
  output logic                   sync_clock_pin_o,
  output logic                   sync_clock_pin_oe_o,
  output logic                   reset_pin_o,
  output logic                   reset_pin_oe_o
);
  import rmf_pkg::*;

  // Two-flop synchronisers on every asynchronous input
  localparam int unsigned NS = 4 + 7 + 4;
  logic [NS-1:0] meta_q, sync_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {enable_select_a_i, enable_select_b_i, clock_pin_config_i,
                 sync_clock_pin_i, sense_i, boost_i};
      sync_q <= meta_q;
    end
  end
  rmf_sense_t sn;
  rmf_boost_t bs;
  logic en_a, en_b, clk_sel_open, sync_in, rt_done;
  assign {en_a, en_b, clk_sel_open, sync_in, sn, bs} = sync_q;

  // Pins have pull-downs; undriven reads low so mode is off
  rmf_mode_t mode;
  assign mode = rmf_mode_t'({en_a, en_b});
  assign mode_o = mode;
  logic enabled;
  assign enabled = (mode != RMF_MODE_OFF);

  // Microsecond tick from the system clock
  logic [6:0] tdiv_q;
  logic       tick;
  assign tick = (tdiv_q == 7'(TICK_CYC - 1));
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) tdiv_q <= '0;
    else if (tick) tdiv_q <= '0;
    else tdiv_q <= tdiv_q + 7'h01;
  end

  // Switcher and linear fault machines share one structure
  logic [1:0] oc;
  assign oc[0] = sn.sw_i_peak;
  assign oc[1] = sn.cs_tied_boost ? sn.ldo_drv_sat : sn.ldo_cs_trip;
  rmf_fault_st_t  st_q [2];
  logic [CNT_W-1:0] fcnt_q [2];
  for (genvar g = 0; g < 2; g++) begin : g_fault
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        st_q[g]   <= RMF_F_OFF;
        fcnt_q[g] <= '0;
      end else if (!enabled) begin
        st_q[g]   <= RMF_F_OFF;
        fcnt_q[g] <= '0;
      end else begin
        case (st_q[g])
          RMF_F_OFF: st_q[g] <= RMF_F_RUN;
          RMF_F_RUN: begin
            fcnt_q[g] <= '0;
            if (oc[g]) st_q[g] <= RMF_F_LIMIT;
          end
          RMF_F_LIMIT: begin
            if (!oc[g]) begin
              st_q[g]   <= RMF_F_RUN;
              fcnt_q[g] <= '0;
            end else if (fcnt_q[g] == CNT_W'(FAULT_TICKS_P - 1) && tick) begin
              st_q[g]   <= RMF_F_RETRY;
              fcnt_q[g] <= '0;
            end else if (tick) fcnt_q[g] <= fcnt_q[g] + 1'b1;
          end
          RMF_F_RETRY: begin
            if (fcnt_q[g] == CNT_W'(RETRY_TICKS_P - 1) && tick) begin
              st_q[g]   <= RMF_F_RUN;
              fcnt_q[g] <= '0;
            end else if (tick) fcnt_q[g] <= fcnt_q[g] + 1'b1;
          end
          default: st_q[g] <= RMF_F_OFF;
        endcase
      end
    end
  end

  // A shut regulator forces the other off too, keeping rails in step
  logic any_retry;
  assign any_retry = (st_q[0] == RMF_F_RETRY) || (st_q[1] == RMF_F_RETRY);

  // Peak/valley hysteresis on the high-side switch
  logic hs_block_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) hs_block_q <= 1'b0;
    else if (sn.sw_i_peak) hs_block_q <= 1'b1;
    else if (sn.sw_i_valley) hs_block_q <= 1'b0;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sw_enable_o    <= 1'b0;
      ldo_enable_o   <= 1'b0;
      sw_high_side_o <= 1'b0;
      ldo_limit_o    <= 1'b0;
      sw_sync_o      <= 1'b0;
    end else begin
      sw_enable_o  <= enabled && !any_retry;
      ldo_enable_o <= enabled && !any_retry;
      sw_high_side_o <= enabled && !any_retry && !hs_block_q;
      ldo_limit_o  <= (st_q[1] == RMF_F_LIMIT);
      sw_sync_o    <= (st_q[0] != RMF_F_LIMIT);
    end
  end

  // Oscillator: 300kHz by division, the default without trim
  logic [OSC_W-1:0] odiv_q;
  logic             osc_q, out_clk_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      odiv_q <= '0;
      osc_q  <= 1'b0;
    end else if (odiv_q == OSC_W'(OSC_HALF_CYC - 1)) begin
      odiv_q <= '0;
      osc_q  <= ~osc_q;
    end else odiv_q <= odiv_q + 1'b1;
  end
  // External sync assumed 200-400kHz with pulses of 1us or more
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) out_clk_q <= 1'b0;
    else out_clk_q <= ~osc_q;
  end
  assign sync_clock_pin_o    = out_clk_q;
  assign sync_clock_pin_oe_o = clk_sel_open;

  // Boost switch hysteresis; comparator thresholds scale above 6V
  logic bst_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) bst_q <= 1'b0;
    else if (bs.bst_at_limit) bst_q <= 1'b0;
    else if (bs.bst_i_upper) bst_q <= 1'b0;
    else if (bs.bst_i_valley) bst_q <= 1'b1;
  end
  assign boost_switch_o = bst_q;

  // Reset: filter, delay, open drain
  logic both_ok;
  assign both_ok = sn.sw_out_ok && sn.ldo_out_ok && enabled &&
                   (st_q[0] != RMF_F_RETRY) && (st_q[1] != RMF_F_RETRY);
  logic [5:0]       filt_q;
  logic             bad_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      filt_q <= '0;
      bad_q  <= 1'b1;
    end else if (!enabled) begin
      filt_q <= '0;
      bad_q  <= 1'b1;
    end else if (both_ok) begin
      filt_q <= '0;
      bad_q  <= 1'b0;
    end else if (filt_q == 6'(FILT_TICKS_P)) bad_q <= 1'b1;
    else if (tick) filt_q <= filt_q + 6'h01;
  end

  // Fixed part then the external RC phase, which ends on its pin
  logic [CNT_W-1:0] dly_q;
  logic             fix_done_q, rst_rel_q;
  logic             rt_m_q, rt_s_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rt_m_q <= 1'b0;
      rt_s_q <= 1'b0;
    end else begin
      rt_m_q <= reset_delay_timer_pin_i;
      rt_s_q <= rt_m_q;
    end
  end
  assign rt_done = rt_s_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dly_q      <= '0;
      fix_done_q <= 1'b0;
      rst_rel_q  <= 1'b0;
    end else if (bad_q) begin
      dly_q      <= '0;
      fix_done_q <= 1'b0;
      rst_rel_q  <= 1'b0;
    end else if (!fix_done_q) begin
      if (tick && dly_q == CNT_W'(RST_FIX_P - 1)) fix_done_q <= 1'b1;
      else if (tick) dly_q <= dly_q + 1'b1;
    end else if (rt_done) rst_rel_q <= 1'b1;
  end
  assign reset_pin_o    = 1'b0;
  assign reset_pin_oe_o = !rst_rel_q;

  a_fault_to_retry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_q[0] == RMF_F_LIMIT && oc[0] && tick && enabled &&
     fcnt_q[0] == CNT_W'(FAULT_TICKS_P - 1)) |=> st_q[0] == RMF_F_RETRY)
    else $error("switcher fault did not shut off");
  a_retry_to_run: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_q[1] == RMF_F_RETRY && tick && enabled &&
     fcnt_q[1] == CNT_W'(RETRY_TICKS_P - 1)) |=> st_q[1] == RMF_F_RUN)
    else $error("linear retry did not restart");
  a_disable_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !enabled |=> st_q[0] == RMF_F_OFF && st_q[1] == RMF_F_OFF && bad_q)
    else $error("disable did not clear state");
  a_rst_held_bad: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    bad_q |=> reset_pin_oe_o)
    else $error("reset released while bad");
  a_rst_od_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reset_pin_o == 1'b0)
    else $error("reset driven high");
  a_rst_needs_fix: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(rst_rel_q) |-> fix_done_q && $past(rt_done))
    else $error("reset released early");
  a_retry_both_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    any_retry |=> !sw_enable_o && !ldo_enable_o)
    else $error("regulator on during retry");
  a_boost_limit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    bs.bst_at_limit |=> !boost_switch_o)
    else $error("boost on at limit");
  a_hs_peak_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sn.sw_i_peak |=> ##1 !sw_high_side_o)
    else $error("high side on after peak");
  a_clk_pin_dir: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sync_clock_pin_oe_o == clk_sel_open)
    else $error("clock pin direction wrong");
  a_clk_inverted: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) |-> out_clk_q == !$past(osc_q))
    else $error("clock output not inverted");
endmodule : rmf_ctrl
`default_nettype wire

// ===== test/rmf_cpu_model.sv
/*
  Far-side model: supplied processor with reset pull-up, plus the
  external sync clock source. Assumes open-drain reset from the block.
*/
`timescale 1ns/1ns
`default_nettype none
module rmf_cpu_model (
  input  wire logic rst_pin_i,
  input  wire logic rst_oe_i,
  input  wire logic clk_oe_i,
  input  wire logic clk_pin_i,
  output logic      rst_line_o,
  output logic      sync_line_o
);
  logic ext_q = 1'b0;
  // 250kHz with 2us pulses, well inside the allowed window
  always #2000 ext_q = ~ext_q;
  // Released line floats up to the pull-up level
  assign rst_line_o = rst_oe_i ? rst_pin_i : 1'b1;
  assign sync_line_o = clk_oe_i ? clk_pin_i : ext_q;
endmodule // rmf_cpu_model
`default_nettype wire

// ===== test/rmf_ctrl_tb_top.sv
/*
  Testbench for rmf_ctrl with shortened counts (tick = 100 cycles).
  Assumes the rmf_cpu_model partner and a 100 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module rmf_ctrl_tb_top;
  import rmf_pkg::*;
  logic       clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       en_a = 1'b0;
  logic       en_b = 1'b0;
  logic       cfg = 1'b1;
  logic       rt = 1'b0;
  rmf_sense_t sn = 7'b0000011;
  rmf_boost_t bs = 4'b0000;
  logic [1:0] mode;
  logic       sw_en, sw_hs, sw_sy, ldo_en, ldo_lim, bst;
  logic       ck_o, ck_oe, rp_o, rp_oe, rst_line, sync_line;
  int         n_errors = 0;
  int         tests_run = 0;
  always #5 clk_i = ~clk_i;
  rmf_ctrl #(.FAULT_TICKS_P(5), .RETRY_TICKS_P(10), .RST_FIX_P(5),
    .FILT_TICKS_P(3)) rmf_ctrl_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .enable_select_a_i(en_a),
    .enable_select_b_i(en_b), .clock_pin_config_i(cfg),
    .sync_clock_pin_i(sync_line), .reset_delay_timer_pin_i(rt),
    .sense_i(sn), .boost_i(bs), .mode_o(mode), .sw_enable_o(sw_en),
    .sw_high_side_o(sw_hs), .sw_sync_o(sw_sy), .ldo_enable_o(ldo_en),
    .ldo_limit_o(ldo_lim), .boost_switch_o(bst),
    .sync_clock_pin_o(ck_o), .sync_clock_pin_oe_o(ck_oe),
    .reset_pin_o(rp_o), .reset_pin_oe_o(rp_oe));
  rmf_cpu_model rmf_cpu_model_inst (
    .rst_pin_i(rp_o), .rst_oe_i(rp_oe), .clk_oe_i(ck_oe),
    .clk_pin_i(ck_o), .rst_line_o(rst_line), .sync_line_o(sync_line));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic tk(input int n);
    cyc(100 * n);
  endtask
  task automatic chk(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch t=%0t got %b exp %b", $time, g, e);
    end
  endtask
  task automatic chk_mode(input logic [1:0] g, input logic [1:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch t=%0t mode got %b exp %b", $time, g, e);
    end
  endtask
  task automatic t_mode;
    for (int i = 0; i < 4; i++) begin
      {en_a, en_b} = i[1:0];
      cyc(4);
      chk_mode(mode, i[1:0]);
    end
    $display("test mode done");
  endtask
  task automatic t_reset;
    {en_a, en_b} = 2'b01;
    tk(8);
    chk(rst_line, 1'b0);
    chk(sw_en, 1'b1);
    rt = 1'b1;
    cyc(6);
    chk(rst_line, 1'b1);
    {en_a, en_b} = 2'b00;
    cyc(6);
    chk(rst_line, 1'b0);
    chk(sw_en, 1'b0);
    {en_a, en_b} = 2'b01;
    tk(3);
    chk(rst_line, 1'b0);
    tk(5);
    chk(rst_line, 1'b1);
    $display("test reset delay done");
  endtask
  task automatic t_filter;
    sn.sw_out_ok = 1'b0;
    tk(1);
    sn.sw_out_ok = 1'b1;
    tk(1);
    chk(rst_line, 1'b1);
    sn.ldo_out_ok = 1'b0;
    tk(6);
    chk(rst_line, 1'b0);
    sn.ldo_out_ok = 1'b1;
    tk(10);
    chk(rst_line, 1'b1);
    $display("test filter done");
  endtask
  task automatic t_sw_fault;
    sn.sw_i_peak = 1'b1;
    cyc(6);
    chk(sw_hs, 1'b0);
    chk(sw_sy, 1'b0);
    tk(8);
    chk(sw_en, 1'b0);
    chk(ldo_en, 1'b0);
    sn.sw_i_peak = 1'b0;
    tk(4);
    chk(sw_en, 1'b0);
    tk(8);
    chk(sw_en, 1'b1);
    chk(sw_sy, 1'b1);
    sn.sw_i_valley = 1'b1;
    cyc(6);
    chk(sw_hs, 1'b1);
    sn.sw_i_valley = 1'b0;
    $display("test switcher fault done");
  endtask
  task automatic t_ldo_fault;
    {sn.cs_tied_boost, sn.ldo_drv_sat} = 2'b11;
    tk(2);
    chk(ldo_lim, 1'b1);
    tk(6);
    chk(ldo_en, 1'b0);
    {sn.cs_tied_boost, sn.ldo_drv_sat} = 2'b00;
    tk(14);
    chk(ldo_en, 1'b1);
    sn.ldo_cs_trip = 1'b1;
    cyc(6);
    chk(ldo_lim, 1'b1);
    sn.ldo_cs_trip = 1'b0;
    cyc(6);
    chk(ldo_lim, 1'b0);
    $display("test linear fault done");
  endtask
  task automatic t_boost;
    bs.bst_i_upper = 1'b1;
    cyc(4);
    chk(bst, 1'b0);
    {bs.bst_i_upper, bs.bst_i_valley} = 2'b01;
    cyc(4);
    chk(bst, 1'b1);
    bs.bst_at_limit = 1'b1;
    cyc(4);
    chk(bst, 1'b0);
    bs.bst_at_limit = 1'b0;
    cyc(4);
    chk(bst, 1'b1);
    {bs.bst_i_upper, bs.bst_i_valley} = 2'b10;
    cyc(4);
    chk(bst, 1'b0);
    bs.bst_i_upper = 1'b0;
    $display("test boost done");
  endtask
  task automatic t_clock;
    int n;
    n = 0;
    chk(ck_oe, 1'b1);
    for (int i = 0; i < 400 && ck_o !== 1'b0; i++) cyc(1);
    for (int i = 0; i < 400 && ck_o !== 1'b1; i++) cyc(1);
    while (ck_o === 1'b1 && n < 400) begin
      n++;
      cyc(1);
    end
    chk(n == OSC_HALF_CYC, 1'b1);
    cfg = 1'b0;
    cyc(4);
    chk(ck_oe, 1'b0);
    $display("test clock pin done");
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Run needs about 8k cycles; limit at 30k keeps a hang short
  initial begin
    #300_000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    cyc(8);
    rst_n_i = 1'b1;
    cyc(2);
    t_mode();
    t_reset();
    t_filter();
    t_sw_fault();
    t_ldo_fault();
    t_boost();
    t_clock();
    tally_and_finish();
  end
endmodule // rmf_ctrl_tb_top
`default_nettype wire
